/* hw/css_defs.vh */
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH

// Register word addresses
`define CSS_A_CTRL    8'h00
`define CSS_A_STAT    8'h01
`define CSS_A_WDOG    8'h02
`define CSS_A_SCAN    8'h03
`define CSS_A_RETAIN  8'h04
`define CSS_A_FORCE   8'h05
`define CSS_A_SYSW    8'h06
`define CSS_A_SYSR    8'h07
`define CSS_A_IMG     8'h08
`define CSS_A_IMG_TOP 8'h0e
`define CSS_A_DREG    8'h10
`define CSS_A_DR_TOP  8'h17

// Control register fields
`define CSS_CTRL_RUN  0
`define CSS_CTRL_STOP 1
`define CSS_CTRL_CLR  2

// Force register fields
`define CSS_FRC_VAL   7
`define CSS_FRC_OVR   8
`define CSS_FRC_REM   9

// Retention mask fields
`define CSS_RET_CTL   0
`define CSS_RET_DREG  1
`define CSS_RET_TMR   2
`define CSS_RET_CNT   3
`define CSS_RETAIN_RST 4'h2

// Image layout, flat bit index
`define CSS_IMG_BITS  112
`define CSS_IMG_OUT   7'd32
`define CSS_IMG_END   7'd112

// Watchdog limit in milliseconds
`define CSS_WD_RST    16'd200
`define CSS_WD_MIN    16'd5
`define CSS_WD_MAX    16'd10000

// Timing
`define CSS_CLK_NS    5
`define CSS_MS_NS     1000000

`endif

/* hw/css_seq.v */
`timescale 1ns/1ps
`include "css_defs.vh"

module css_seq #(
   parameter MS_CYCLES = `CSS_MS_NS / `CSS_CLK_NS
) (
   // Clock and reset
   input  wire        clock_in,
   input  wire        rst_b_in,
   // Register port
   input  wire [7:0]  reg_addr_in,
   input  wire [15:0] reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output reg  [15:0] reg_rdata_out,
   // Field pins
   input  wire [31:0] pin_in_in,
   input  wire        mode_sw_run_in,
   input  wire        usb_low_pwr_in,
   input  wire        err_fatal_in,
   input  wire        err_nonfatal_in,
   output reg  [31:0] pin_out_out,
   // Program solve engine
   output reg         solve_go_out,
   input  wire        solve_done_in,
   input  wire        sol_wr_in,
   input  wire [6:0]  sol_addr_in,
   input  wire        sol_bit_in,
   input  wire        sol_imm_in,
   output reg         sol_rdata_out,
   input  wire        sol_dw_in,
   input  wire [2:0]  sol_daddr_in,
   input  wire [15:0] sol_dwdata_in,
   // Status
   output reg         run_mode_out,
   output reg  [2:0]  segment_out
);

   // Scan segments
   localparam [2:0] S_INIT  = 3'd0;
   localparam [2:0] S_READ  = 3'd1;
   localparam [2:0] S_SERV  = 3'd2;
   localparam [2:0] S_SYS   = 3'd3;
   localparam [2:0] S_SOLVE = 3'd4;
   localparam [2:0] S_WRITE = 3'd5;
   localparam [2:0] S_DIAG  = 3'd6;
   localparam [31:0] MS_LAST = MS_CYCLES - 1;

   // Overrides take priority over any image write
   function [`CSS_IMG_BITS-1:0] ovr_apply;
      input [`CSS_IMG_BITS-1:0] img;
      input [`CSS_IMG_BITS-1:0] en;
      input [`CSS_IMG_BITS-1:0] val;
      begin
         ovr_apply = (img & ~en) | (val & en);
      end
   endfunction
   // Valid image bit index
   function in_img;
      input [6:0] idx;
      begin
         in_img = (idx < `CSS_IMG_END);
      end
   endfunction
   reg  [35:0]              sync1_r;
   reg  [35:0]              sync2_r;
   reg  [2:0]               state_r;
   reg  [3:0]               init_idx_r;
   reg  [`CSS_IMG_BITS-1:0] img_r;
   reg  [`CSS_IMG_BITS-1:0] img_nxt;
   reg  [`CSS_IMG_BITS-1:0] ovr_en_r;
   reg  [`CSS_IMG_BITS-1:0] ovr_val_r;
   reg  [15:0]              dreg_r [0:7];
   reg                      run_r;
   reg                      fatal_r;
   reg                      nfe_r;
   reg                      wdtrip_r;
   reg                      reject_r;
   reg                      sw_prev_r;
   reg                      first_r;
   reg  [15:0]              wd_lim_r;
   reg  [15:0]              wd_ms_r;
   reg  [31:0]              tick_cnt_r;
   reg                      tick_r;
   reg  [15:0]              scan_cyc_r;
   reg  [15:0]              scan_avg_r;
   reg  [15:0]              scan_cnt_r;
   reg  [15:0]              sys_relay_r;
   reg  [3:0]               retain_r;
   reg                      frc_pend_r;
   reg  [6:0]               frc_idx_r;
   reg                      frc_val_r;
   reg  [16:0]              avg_sum;
   wire [31:0]              pins_s;
   wire                     sw_run_s;
   wire                     low_pwr_s;
   wire                     fatal_s;
   wire                     nonfatal_s;
   wire                     wd_over;
   wire                     wr_ctrl;
   wire                     wr_setup;
   // Two-stage synchronisers for all pins
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         sync1_r <= 36'h0;
         sync2_r <= 36'h0;
      end else begin
         sync1_r <= {err_nonfatal_in, err_fatal_in, usb_low_pwr_in, mode_sw_run_in, pin_in_in};
         sync2_r <= sync1_r;
      end
   end
   assign pins_s     = sync2_r[31:0];
   assign sw_run_s   = sync2_r[32];
   assign low_pwr_s  = sync2_r[33];
   assign fatal_s    = sync2_r[34];
   assign nonfatal_s = sync2_r[35];
   // Millisecond tick, restarted at solve start
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b0;
      end else if (state_r != S_SOLVE || tick_cnt_r == MS_LAST) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= (state_r == S_SOLVE);
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
         tick_r     <= 1'b0;
      end
   end
   assign wd_over  = (state_r == S_SOLVE) && (wd_ms_r >= wd_lim_r);
   assign wr_ctrl  = reg_wr_in && (reg_addr_in == `CSS_A_CTRL);
   assign wr_setup = reg_wr_in && !run_r;
   // Next image: capture, forces, solve writes, then overrides
   always @* begin
      img_nxt = img_r;
      case (state_r)
         S_INIT: begin
            if (init_idx_r == 4'h0) begin
               img_nxt[63:0] = 64'h0;
               if (!retain_r[`CSS_RET_CTL])
                  img_nxt[79:64] = 16'h0;
               if (!retain_r[`CSS_RET_TMR])
                  img_nxt[95:80] = 16'h0;
               if (!retain_r[`CSS_RET_CNT])
                  img_nxt[111:96] = 16'h0;
            end
         end
         S_READ: begin
            img_nxt[31:0] = pins_s;
         end
         S_SERV: begin
            if (frc_pend_r && in_img(frc_idx_r))
               img_nxt[frc_idx_r] = frc_val_r;
         end
         S_SOLVE: begin
            if (sol_wr_in && sol_addr_in >= `CSS_IMG_OUT && in_img(sol_addr_in))
               img_nxt[sol_addr_in] = sol_bit_in;
         end
         default: img_nxt = img_r;
      endcase
      img_nxt = ovr_apply(img_nxt, ovr_en_r, ovr_val_r);
   end
   // Image and data registers, retentive parts have no reset
   always @(posedge clock_in) begin
      img_r <= img_nxt;
      if (state_r == S_INIT && !retain_r[`CSS_RET_DREG] && !init_idx_r[3])
         dreg_r[init_idx_r[2:0]] <= 16'h0;
      else if (state_r == S_SOLVE && sol_dw_in)
         dreg_r[sol_daddr_in] <= sol_dwdata_in;
      else if (reg_wr_in && reg_addr_in >= `CSS_A_DREG && reg_addr_in <= `CSS_A_DR_TOP)
         dreg_r[reg_addr_in[2:0]] <= reg_wdata_in;
   end
   // Scan sequencer
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         state_r      <= S_INIT;
         init_idx_r   <= 4'h0;
         solve_go_out <= 1'b0;
         segment_out  <= S_INIT;
      end else begin
         solve_go_out <= 1'b0;
         case (state_r)
            S_INIT: begin
               init_idx_r <= init_idx_r + 4'h1;
               if (init_idx_r == 4'h8)
                  state_r <= S_READ;
            end
            S_READ:  state_r <= S_SERV;
            S_SERV:  state_r <= S_SYS;
            S_SYS: begin
               if (run_r) begin
                  state_r      <= S_SOLVE;
                  solve_go_out <= 1'b1;
               end else begin
                  state_r <= S_WRITE;
               end
            end
            S_SOLVE: begin
               if (solve_done_in || wd_over)
                  state_r <= S_WRITE;
               else
                  solve_go_out <= 1'b1;
            end
            S_WRITE: state_r <= S_DIAG;
            S_DIAG:  state_r <= S_READ;
            default: state_r <= S_INIT;
         endcase
         segment_out <= state_r;
      end
   end
   // Operating mode and error flags
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         run_r     <= 1'b0;
         fatal_r   <= 1'b0;
         nfe_r     <= 1'b0;
         wdtrip_r  <= 1'b0;
         reject_r  <= 1'b0;
         sw_prev_r <= 1'b0;
      end else begin
         sw_prev_r <= sw_run_s;
         // Clears first, so an event in the same cycle wins
         if (wr_ctrl && reg_wdata_in[`CSS_CTRL_CLR]) begin
            fatal_r  <= 1'b0;
            nfe_r    <= 1'b0;
            wdtrip_r <= 1'b0;
            reject_r <= 1'b0;
         end
         if (wr_ctrl && (reg_wdata_in[`CSS_CTRL_RUN] || reg_wdata_in[`CSS_CTRL_STOP])) begin
            if (!sw_run_s)
               reject_r <= 1'b1;
            else if (reg_wdata_in[`CSS_CTRL_STOP])
               run_r <= 1'b0;
            else if (!low_pwr_s && !fatal_r)
               run_r <= 1'b1;
         end
         if (sw_run_s && !sw_prev_r && !low_pwr_s && !fatal_r)
            run_r <= 1'b1;
         if (!sw_run_s)
            run_r <= 1'b0;
         if (state_r == S_DIAG && nonfatal_s)
            nfe_r <= 1'b1;
         if (state_r == S_DIAG && fatal_s) begin
            fatal_r <= 1'b1;
            run_r   <= 1'b0;
         end
         if (wd_over) begin
            fatal_r  <= 1'b1;
            wdtrip_r <= 1'b1;
            run_r    <= 1'b0;
         end
      end
   end
   // Physical outputs, off whenever not running
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         pin_out_out  <= 32'h0;
         run_mode_out <= 1'b0;
      end else begin
         run_mode_out <= run_r;
         if (!run_r)
            pin_out_out <= 32'h0;
         else if (state_r == S_WRITE)
            pin_out_out <= img_r[63:32];
      end
   end
   // Watchdog, scan time and system status
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         wd_ms_r     <= 16'h0;
         scan_cyc_r  <= 16'h0;
         scan_avg_r  <= 16'h0;
         scan_cnt_r  <= 16'h0;
         sys_relay_r <= 16'h0;
         first_r     <= 1'b1;
      end else begin
         if (state_r != S_SOLVE || state_r == S_DIAG)
            wd_ms_r <= 16'h0;
         else if (tick_r && wd_ms_r != 16'hffff)
            wd_ms_r <= wd_ms_r + 16'h1;
         if (state_r == S_DIAG) begin
            scan_cyc_r <= 16'h0;
            scan_avg_r <= avg_sum[16:1];
            first_r    <= 1'b0;
         end else if (state_r != S_INIT && scan_cyc_r != 16'hffff) begin
            scan_cyc_r <= scan_cyc_r + 16'h1;
         end
         if (state_r == S_SYS) begin
            scan_cnt_r  <= scan_cnt_r + 16'h1;
            sys_relay_r <= {9'h0, reject_r, wdtrip_r, low_pwr_s, sw_run_s, nfe_r, run_r, first_r};
         end
      end
   end
   // Running average of scan length in cycles
   always @* begin
      avg_sum = {1'b0, scan_avg_r} + {1'b0, scan_cyc_r};
   end
   // Setup registers and peripheral forces
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         wd_lim_r   <= `CSS_WD_RST;
         retain_r   <= `CSS_RETAIN_RST;
         ovr_en_r   <= {`CSS_IMG_BITS{1'b0}};
         ovr_val_r  <= {`CSS_IMG_BITS{1'b0}};
         frc_pend_r <= 1'b0;
         frc_idx_r  <= 7'h0;
         frc_val_r  <= 1'b0;
      end else begin
         if (state_r == S_SERV)
            frc_pend_r <= 1'b0;
         if (wr_setup && reg_addr_in == `CSS_A_WDOG) begin
            if (reg_wdata_in < `CSS_WD_MIN)
               wd_lim_r <= `CSS_WD_MIN;
            else if (reg_wdata_in > `CSS_WD_MAX)
               wd_lim_r <= `CSS_WD_MAX;
            else
               wd_lim_r <= reg_wdata_in;
         end
         if (wr_setup && reg_addr_in == `CSS_A_RETAIN)
            retain_r <= reg_wdata_in[3:0];
         if (reg_wr_in && reg_addr_in == `CSS_A_FORCE && in_img(reg_wdata_in[6:0])) begin
            if (reg_wdata_in[`CSS_FRC_REM]) begin
               ovr_en_r[reg_wdata_in[6:0]] <= 1'b0;
            end else if (reg_wdata_in[`CSS_FRC_OVR]) begin
               ovr_en_r[reg_wdata_in[6:0]]  <= 1'b1;
               ovr_val_r[reg_wdata_in[6:0]] <= reg_wdata_in[`CSS_FRC_VAL];
            end else begin
               frc_pend_r <= 1'b1;
               frc_idx_r  <= reg_wdata_in[6:0];
               frc_val_r  <= reg_wdata_in[`CSS_FRC_VAL];
            end
         end
      end
   end
   // Solve engine bit reads, immediate ones see live pins
   always @(posedge clock_in) begin
      if (!rst_b_in)
         sol_rdata_out <= 1'b0;
      else if (sol_imm_in && sol_addr_in < `CSS_IMG_OUT)
         sol_rdata_out <= pins_s[sol_addr_in[4:0]];
      else if (in_img(sol_addr_in))
         sol_rdata_out <= img_r[sol_addr_in];
      else
         sol_rdata_out <= 1'b0;
   end
   // Register read data, one cycle after the strobe
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 16'h0;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `CSS_A_CTRL:   reg_rdata_out <= 16'h0;
            `CSS_A_STAT:   reg_rdata_out <= {5'h0, state_r, 1'b0, reject_r, wdtrip_r, nfe_r,
                                             fatal_r, low_pwr_s, sw_run_s, run_r};
            `CSS_A_WDOG:   reg_rdata_out <= wd_lim_r;
            `CSS_A_SCAN:   reg_rdata_out <= scan_avg_r;
            `CSS_A_RETAIN: reg_rdata_out <= {12'h0, retain_r};
            `CSS_A_SYSW:   reg_rdata_out <= scan_cnt_r;
            `CSS_A_SYSR:   reg_rdata_out <= sys_relay_r;
            default: begin
               if (reg_addr_in >= `CSS_A_IMG && reg_addr_in <= `CSS_A_IMG_TOP)
                  reg_rdata_out <= img_r[{reg_addr_in[2:0], 4'h0} +: 16];
               else if (reg_addr_in >= `CSS_A_DREG && reg_addr_in <= `CSS_A_DR_TOP)
                  reg_rdata_out <= dreg_r[reg_addr_in[2:0]];
               else
                  reg_rdata_out <= 16'h0;
            end
         endcase
      end
   end
endmodule // css_seq

/* verif/css_seq_monitor.sv */
`timescale 1ns/1ps
`include "css_defs.vh"
// Port-level checks on the scan sequencer
module css_seq_monitor #(
   parameter MS_CYCLES = 10
) (
   input wire        clock_in,
   input wire        rst_b_in,
   input wire [7:0]  reg_addr_in,
   input wire        reg_rd_in,
   input wire [15:0] reg_rdata_out,
   input wire        solve_done_in,
   input wire [31:0] pin_out_out,
   input wire        solve_go_out,
   input wire        run_mode_out,
   input wire [2:0]  segment_out
);
   reg [31:0] sol_cnt_r;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // Length of the current solve segment
   always @(posedge clock_in) begin
      if (!rst_b_in || !solve_go_out) sol_cnt_r <= 32'h0;
      else sol_cnt_r <= sol_cnt_r + 32'h1;
   end
   out_off_a: assert property (!run_mode_out && !$past(run_mode_out) |-> pin_out_out == 32'h0)
      else $error("outputs on outside run");
   solve_run_a: assert property ($rose(solve_go_out) |-> run_mode_out)
      else $error("solve entered in stop");
   solve_end_a: assert property (solve_go_out && solve_done_in |=> !solve_go_out)
      else $error("solve did not end on done");
   seg_step_a: assert property (segment_out != 3'd0 && segment_out != 3'd3 && segment_out != 3'd4
      |=> segment_out == (($past(segment_out) == 3'd6) ? 3'd1 : $past(segment_out) + 3'd1))
      else $error("segment order broken");
   seg_sys_a: assert property (segment_out == 3'd3 |=> segment_out == 3'd4 || segment_out == 3'd5)
      else $error("segment after system update wrong");
   wd_bound_a: assert property (sol_cnt_r <= 200 * MS_CYCLES + 4)
      else $error("solve ran past watchdog limit");
   rd_zero_a: assert property (reg_rd_in && (reg_addr_in == `CSS_A_CTRL || reg_addr_in > `CSS_A_DR_TOP)
      |=> reg_rdata_out == 16'h0)
      else $error("write-only or unmapped read not zero");
   pin_write_a: assert property ($changed(pin_out_out) && run_mode_out |-> segment_out == 3'd5)
      else $error("outputs changed outside write");
endmodule // css_seq_monitor
bind css_seq css_seq_monitor #(.MS_CYCLES(MS_CYCLES)) mon_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
   .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .solve_done_in(solve_done_in), .pin_out_out(pin_out_out), .solve_go_out(solve_go_out),
   .run_mode_out(run_mode_out), .segment_out(segment_out));

/* verif/css_solve_model.sv */
`timescale 1ns/1ps
// Solve engine stand-in at the far side of the sequencer
module css_solve_model (
   // Clock
   input  wire        clock_in,
   // Sequencer side
   input  wire        go_in,
   output reg         done_out,
   output reg         wr_out,
   output wire [6:0]  addr_out,
   output wire        bit_out,
   output wire        imm_out,
   output reg         dw_out,
   output wire [2:0]  daddr_out,
   output wire [15:0] dwdata_out,
   // Test control
   input  wire [6:0]  wa_in,
   input  wire        wb_in,
   input  wire [15:0] dv_in,
   input  wire [15:0] dly_in,
   input  wire [6:0]  ra_in,
   input  wire        imm_in
);
   reg [15:0] cnt_r;
   // Idle write lines show inverted values; address carries the read index between writes
   assign addr_out   = wr_out ? wa_in : ra_in;
   assign bit_out    = wr_out ? wb_in : ~wb_in;
   assign daddr_out  = dw_out ? 3'h7 : 3'h0;
   assign dwdata_out = dw_out ? dv_in : ~dv_in;
   assign imm_out    = imm_in;
   initial begin
      done_out = 1'b0;
      wr_out = 1'b0;
      dw_out = 1'b0;
      cnt_r = 16'h0;
   end
   // Writes once on solve entry, ends solve after dly_in cycles
   always @(posedge clock_in) begin
      wr_out <= 1'b0;
      dw_out <= 1'b0;
      done_out <= 1'b0;
      if (!go_in) begin
         cnt_r <= 16'h0;
      end else begin
         cnt_r <= cnt_r + 16'h1;
         if (cnt_r == 16'h0) begin
            wr_out <= 1'b1;
            dw_out <= 1'b1;
         end
         if (cnt_r == dly_in) begin
            done_out <= 1'b1;
         end
      end
   end
endmodule // css_solve_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
`include "css_defs.vh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb_top;
   reg clock_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   reg [7:0] reg_addr_in = 8'h0;
   reg [15:0] reg_wdata_in = 16'h0, dv = 16'h0, dly = 16'h3, v, w;
   reg [31:0] pin_in_in = 32'h0;
   reg sw = 1'b0, usb = 1'b0, ef = 1'b0, en = 1'b0, wb = 1'b1;
   reg [6:0] wa = 7'd32;
   reg [6:0] ra = 7'd0;
   reg imm = 1'b0;
   wire [15:0] rdata;
   wire [31:0] pout;
   wire go, done, swr, sbit, simm, sdw, srd, run;
   wire [6:0] sadr;
   wire [2:0] sda, seg;
   wire [15:0] sdd;
   int n_fail = 0, checks = 0, cyc_n = 0;
   // 200 MHz clock
   always #2.5 clock_in = ~clock_in;
   css_seq #(.MS_CYCLES(10)) css_seq_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
      .pin_in_in(pin_in_in), .mode_sw_run_in(sw), .usb_low_pwr_in(usb), .err_fatal_in(ef),
      .err_nonfatal_in(en), .pin_out_out(pout), .solve_go_out(go), .solve_done_in(done), .sol_wr_in(swr),
      .sol_addr_in(sadr), .sol_bit_in(sbit), .sol_imm_in(simm), .sol_rdata_out(srd), .sol_dw_in(sdw),
      .sol_daddr_in(sda), .sol_dwdata_in(sdd), .run_mode_out(run), .segment_out(seg));
   css_solve_model css_solve_model_i (.clock_in(clock_in), .go_in(go), .done_out(done), .wr_out(swr),
      .addr_out(sadr), .bit_out(sbit), .imm_out(simm), .dw_out(sdw), .daddr_out(sda), .dwdata_out(sdd),
      .wa_in(wa), .wb_in(wb), .dv_in(dv), .dly_in(dly), .ra_in(ra), .imm_in(imm));
   task cyc(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task wr(input [7:0] a, input [15:0] d);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
   endtask
   task rd(input [7:0] a);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      #1 v = rdata;
   endtask
   task rc(input [7:0] a, input [15:0] e, input string nm);
      rd(a);
      `CHK(nm, e, v)
   endtask
   // Expected watchdog limit after a clamped write
   function [15:0] wd_clamp(input [15:0] d);
      wd_clamp = (d < `CSS_WD_MIN) ? `CSS_WD_MIN : ((d > `CSS_WD_MAX) ? `CSS_WD_MAX : d);
   endfunction
   task rst;
      rst_b_in <= 1'b0;
      cyc(5);
      rst_b_in <= 1'b1;
      cyc(14);
   endtask
   task wrap_up;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock_in) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         n_fail++;
         wrap_up;
      end
   end
   // Main sequence
   initial begin
      void'($urandom(88981));
      rst;
      rc(`CSS_A_WDOG, 16'd200, "wdog rst");
      rc(`CSS_A_RETAIN, `CSS_RETAIN_RST, "retain rst");
      rc(8'h3f, 16'h0, "unmapped");
      wr(`CSS_A_WDOG, 16'd1);
      rc(`CSS_A_WDOG, `CSS_WD_MIN, "wdog low");
      wr(`CSS_A_WDOG, 16'd20000);
      rc(`CSS_A_WDOG, `CSS_WD_MAX, "wdog high");
      w = $urandom % 12000;
      wr(`CSS_A_WDOG, w);
      rc(`CSS_A_WDOG, wd_clamp(w), "wdog rand");
      wr(`CSS_A_WDOG, 16'd200);
      $display("test limits done");
      w = $urandom;
      wr(`CSS_A_DREG, w);
      wr(`CSS_A_FORCE, 16'h00c0);
      cyc(10);
      rc(`CSS_A_IMG + 8'h4, 16'h0001, "relay force");
      rst;
      rc(`CSS_A_DREG, w, "dreg kept");
      rc(`CSS_A_IMG + 8'h4, 16'h0000, "relay clear");
      $display("test retention done");
      pin_in_in <= $urandom;
      cyc(20);
      rc(`CSS_A_IMG, pin_in_in[15:0], "in word0");
      rc(`CSS_A_IMG + 8'h1, pin_in_in[31:16], "in word1");
      wr(`CSS_A_FORCE, 16'h0102 | {8'h0, ~pin_in_in[2], 7'h0});
      cyc(20);
      rd(`CSS_A_IMG);
      `CHK("override", ~pin_in_in[2], v[2])
      ra <= 7'd2;
      cyc(3);
      `CHK("image read", ~pin_in_in[2], srd)
      imm <= 1'b1;
      cyc(3);
      `CHK("live read", pin_in_in[2], srd)
      imm <= 1'b0;
      wr(`CSS_A_FORCE, 16'h0202);
      cyc(20);
      rd(`CSS_A_IMG);
      `CHK("override off", pin_in_in[2], v[2])
      $display("test inputs done");
      wr(`CSS_A_CTRL, 16'h0001);
      cyc(4);
      rd(`CSS_A_STAT);
      `CHK("reject", 2'b10, {v[6], v[0]})
      usb <= 1'b1;
      cyc(4);
      sw <= 1'b1;
      cyc(6);
      wr(`CSS_A_CTRL, 16'h0001);
      cyc(6);
      `CHK("low power", 1'b0, run)
      usb <= 1'b0;
      cyc(4);
      wr(`CSS_A_CTRL, 16'h0005);
      cyc(4);
      `CHK("run req", 1'b1, run)
      wr(`CSS_A_WDOG, 16'd50);
      rc(`CSS_A_WDOG, 16'd200, "wdog in run");
      $display("test modes done");
      wa <= 7'd32 + ($urandom % 16);
      dv <= $urandom;
      cyc(30);
      `CHK("out bit", 1'b1, pout[wa - 7'd32])
      rc(`CSS_A_DREG + 8'h7, dv, "solve dreg");
      rd(`CSS_A_SYSW);
      w = v;
      cyc(20);
      rd(`CSS_A_SYSW);
      `CHK("sys word", 1'b1, v != w)
      en <= 1'b1;
      cyc(20);
      en <= 1'b0;
      rd(`CSS_A_STAT);
      `CHK("nonfatal", 2'b11, {v[4], v[0]})
      wr(`CSS_A_CTRL, 16'h0003);
      cyc(10);
      `CHK("stop outs", 33'h0, {run, pout})
      wr(`CSS_A_CTRL, 16'h0005);
      cyc(10);
      ef <= 1'b1;
      cyc(20);
      ef <= 1'b0;
      `CHK("fatal", 33'h0, {run, pout})
      cyc(4);
      wr(`CSS_A_CTRL, 16'h0004);
      wr(`CSS_A_CTRL, 16'h0001);
      $display("test run done");
      dly <= 16'hffff;
      cyc(2200);
      rd(`CSS_A_STAT);
      `CHK("wd trip", 3'b110, {v[5], v[3], run})
      `CHK("wd outs", 32'h0, pout)
      $display("test watchdog done");
      wrap_up;
   end
endmodule // tb_top
